// ==== src/brli_pkg.sv ====
// Package for the bridge reset and link initialisation sequencer
package brli_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ = 10000000;
	localparam int RESET_HOLD_US = 1000;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_US * (CLK_HZ / 1000000));
	localparam int CNT_W = 14;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] REG_BUS_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LINK_CTRL = 8'h08;
	localparam logic [7:0] REG_LINK0_CMD = 8'h0c;
	localparam logic [7:0] REG_LINK1_CMD = 8'h10;
	localparam logic [7:0] REG_BASE_UID = 8'h14;
	localparam logic [7:0] REG_STRAP = 8'h18;
	localparam logic [7:0] REG_ROM_CFG = 8'h1c;

	// ****************************************************************
	// Fields
	// ****************************************************************
	localparam int BUS_CTRL_SBR = 0;
	localparam int LCTRL_EOC = 0;
	localparam int LCTRL_TXOFF = 2;
	localparam int STRAP_SINGLE = 0;
	localparam int STRAP_32BIT = 1;
	localparam int UID_W = 5;
	localparam logic [UID_W-1:0] UNIT_ID_COUNT = 5'h01;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		BRLI_COLD = 2'b00,
		BRLI_HOLD = 2'b01,
		BRLI_INIT = 2'b11,
		BRLI_RUN = 2'b10
	} brli_state_t;

	typedef struct packed {
		logic pg_m;
		logic pg_s;
		logic rst_m;
		logic rst_s;
		brli_state_t state;
		logic [CNT_W-1:0] cnt;
		logic strap_done;
		logic [31:0] strap;
		logic rom_done;
		logic [31:0] rom_cfg;
		logic [1:0] failed;
		logic [1:0] init_complete;
		logic [1:0] init_busy;
		logic [1:0] chain_end;
		logic [1:0] tx_disable;
		logic [1:0] master_host;
		logic [UID_W-1:0] base_uid;
		logic sbr;
		logic flush;
		logic ob_abort;
		logic rd_discard;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} brli_regs_t;

endpackage

// ==== src/brli_sequencer.sv ====
// Reset, strap capture, link start-up and secondary bus reset sequencer
`timescale 1ns/100ps
module brli_sequencer #(
	parameter int RESET_HOLD_CYCLES = brli_pkg::RESET_HOLD_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic power_good_i,
	input wire logic sys_reset_n_i,
	output logic sys_reset_n_o,
	output logic sys_reset_n_oe_o,
	input wire logic pll_lock_i,
	output logic rom_load_req_o,
	input wire logic rom_load_valid_i,
	input wire logic [31:0] rom_load_data_i,
	input wire logic [31:0] first_port_addr_data_i,
	output logic [1:0] link_init_start_o,
	input wire logic [1:0] link_init_ok_i,
	input wire logic [1:0] link_init_fail_i,
	input wire logic [1:0] sync_flood_i,
	input wire logic [1:0] link_cmd_write_i,
	output logic [1:0] link_tx_enable_o,
	output logic [1:0] chain_end_handle_o,
	input wire logic cfg_req_i,
	input wire logic [4:0] cfg_device_i,
	output logic cfg_claim_o,
	output logic cfg_forward_o,
	output logic [4:0] unit_id_o,
	output logic secondary_bus_reset_n_o,
	output logic buffer_flush_o,
	input wire logic inbound_write_i,
	input wire logic inbound_write_committed_i,
	output logic inbound_write_drop_o,
	input wire logic inbound_read_resp_i,
	output logic read_data_discard_o,
	input wire logic outbound_op_i,
	output logic outbound_master_abort_o,
	output logic port1_clk_enable_o,
	output logic port1_pad_power_down_o
);

	// ****************************************************************
	// State
	// ****************************************************************
	brli_pkg::brli_regs_t r;
	brli_pkg::brli_regs_t next_r;

	logic addr_ok;
	logic [1:0] link_ok;
	logic in_reset;
	logic claim_hit;

	localparam logic [brli_pkg::CNT_W-1:0] HOLD_LAST = RESET_HOLD_CYCLES[brli_pkg::CNT_W-1:0];

	function automatic logic [31:0] rd_mux(input logic [7:0] a,
		input brli_pkg::brli_regs_t s);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			brli_pkg::REG_BUS_CTRL: begin
				v[brli_pkg::BUS_CTRL_SBR] = s.sbr;
			end
			brli_pkg::REG_STATUS: begin
				v[1:0] = s.state;
				v[3:2] = s.init_complete;
				v[5:4] = s.failed;
				v[7:6] = s.master_host;
				v[8] = s.strap_done;
				v[9] = s.rom_done;
			end
			brli_pkg::REG_LINK_CTRL: begin
				v[brli_pkg::LCTRL_EOC +: 2] = s.chain_end;
				v[brli_pkg::LCTRL_TXOFF +: 2] = s.tx_disable;
			end
			brli_pkg::REG_BASE_UID: begin
				v[brli_pkg::UID_W-1:0] = s.base_uid;
				v[15:8] = {3'h0, brli_pkg::UNIT_ID_COUNT};
			end
			brli_pkg::REG_STRAP: begin
				v = s.strap;
			end
			brli_pkg::REG_ROM_CFG: begin
				v = s.rom_cfg;
			end
			default: begin
				v = 32'h0000_0000;
			end
		endcase
		return v;
	endfunction

	function automatic logic release_ready(input brli_pkg::brli_regs_t s,
		input logic lock);
		return (s.cnt == HOLD_LAST) && lock && s.rom_done;
	endfunction

	function automatic logic claim_match(input logic [brli_pkg::UID_W-1:0] base,
		input logic [4:0] dev);
		logic [brli_pkg::UID_W:0] lo;
		logic [brli_pkg::UID_W:0] hi;
		logic [brli_pkg::UID_W:0] d;
		logic hit;
		lo = {1'b0, base};
		hi = lo + {1'b0, brli_pkg::UNIT_ID_COUNT};
		d = {1'b0, dev};
		if (base == '0) begin
			hit = (dev == 5'h00);
		end else begin
			hit = (d >= lo) && (d < hi);
		end
		return hit;
	endfunction

	function automatic logic single_port(input brli_pkg::brli_regs_t s);
		return s.strap_done && s.strap[brli_pkg::STRAP_SINGLE];
	endfunction

	function automatic logic narrow_pads(input brli_pkg::brli_regs_t s);
		return single_port(s) && s.strap[brli_pkg::STRAP_32BIT];
	endfunction

	assign addr_ok = hsel_i && hready_i && (htrans_i == brli_pkg::HTRANS_NONSEQ);
	assign in_reset = (r.state == brli_pkg::BRLI_COLD) || (r.state == brli_pkg::BRLI_HOLD);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_r = r;
		next_r.flush = 1'b0;
		next_r.ob_abort = 1'b0;
		next_r.rd_discard = 1'b0;
		next_r.wr_pend = 1'b0;
		link_ok = ~r.failed;
		// Two-flop synchronisers
		next_r.pg_m = power_good_i;
		next_r.pg_s = r.pg_m;
		next_r.rst_m = sys_reset_n_i;
		next_r.rst_s = r.rst_m;

		// Register writes, data phase
		if (r.wr_pend) begin
			case (r.wr_addr)
				brli_pkg::REG_BUS_CTRL: begin
					next_r.sbr = hwdata_i[brli_pkg::BUS_CTRL_SBR];
					next_r.flush = hwdata_i[brli_pkg::BUS_CTRL_SBR] & ~r.sbr;
				end
				brli_pkg::REG_LINK_CTRL: begin
					next_r.chain_end = hwdata_i[brli_pkg::LCTRL_EOC +: 2];
					next_r.tx_disable = hwdata_i[brli_pkg::LCTRL_TXOFF +: 2];
				end
				brli_pkg::REG_LINK0_CMD: begin
					next_r.master_host = 2'h1;
				end
				brli_pkg::REG_LINK1_CMD: begin
					next_r.master_host = 2'h2;
				end
				brli_pkg::REG_BASE_UID: begin
					next_r.base_uid = hwdata_i[brli_pkg::UID_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// Command writes arriving over a link
		if (link_cmd_write_i[0]) begin
			next_r.master_host = 2'h1;
		end
		if (link_cmd_write_i[1]) begin
			next_r.master_host = 2'h2;
		end

		// Register reads and write address capture
		if (addr_ok) begin
			next_r.wr_pend = hwrite_i;
			next_r.wr_addr = haddr_i[7:0];
			next_r.rdata = hwrite_i ? r.rdata : rd_mux(haddr_i[7:0], r);
		end

		// Secondary bus reset side effects
		if (r.sbr) begin
			next_r.ob_abort = outbound_op_i;
			next_r.rd_discard = inbound_read_resp_i;
		end

		// Link failure is sticky across warm reset
		next_r.failed = r.failed | sync_flood_i;

		// Sequencer
		case (r.state)
			brli_pkg::BRLI_COLD: begin
				next_r.cnt = '0;
				if (r.pg_s) begin
					next_r.state = brli_pkg::BRLI_HOLD;
				end
			end
			brli_pkg::BRLI_HOLD: begin
				if (r.cnt != HOLD_LAST) begin
					next_r.cnt = r.cnt + 1'b1;
				end
				if (!r.strap_done) begin
					next_r.strap = first_port_addr_data_i;
					next_r.strap_done = 1'b1;
				end
				if (!r.rom_done && rom_load_valid_i) begin
					next_r.rom_cfg = rom_load_data_i;
					next_r.rom_done = 1'b1;
				end
				if (sys_reset_n_oe_o == 1'b0 && r.rst_s) begin
					next_r.state = brli_pkg::BRLI_INIT;
					next_r.init_busy = link_ok;
				end
			end
			brli_pkg::BRLI_INIT: begin
				next_r.init_complete = r.init_complete | (r.init_busy & link_init_ok_i);
				next_r.init_busy = r.init_busy & ~link_init_ok_i & ~link_init_fail_i;
				if (next_r.init_busy == 2'h0) begin
					next_r.state = brli_pkg::BRLI_RUN;
				end
			end
			brli_pkg::BRLI_RUN: begin
			end
			default: begin
				next_r.state = brli_pkg::BRLI_COLD;
			end
		endcase
		next_r.init_complete = next_r.init_complete & ~r.failed;

		// Warm reset: pin low with power-good high
		if (!r.rst_s && r.state != brli_pkg::BRLI_HOLD) begin
			next_r.state = brli_pkg::BRLI_HOLD;
			next_r.cnt = '0;
			next_r.init_complete = 2'h0;
			next_r.init_busy = 2'h0;
			next_r.chain_end = 2'h0;
			next_r.tx_disable = 2'h0;
			next_r.master_host = 2'h0;
			next_r.base_uid = '0;
			next_r.sbr = 1'b0;
		end

		// Cold reset clears everything but the synchronisers, which keep sampling
		if (!r.pg_s) begin
			next_r = '0;
			next_r.pg_m = power_good_i;
			next_r.pg_s = r.pg_m;
			next_r.rst_m = sys_reset_n_i;
			next_r.rst_s = r.rst_m;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	always_comb begin
		sys_reset_n_o = 1'b0;
		sys_reset_n_oe_o = (r.state == brli_pkg::BRLI_COLD) ||
			((r.state == brli_pkg::BRLI_HOLD) && !release_ready(r, pll_lock_i));
	end

	assign hrdata_o = r.rdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign rom_load_req_o = (r.state == brli_pkg::BRLI_HOLD) && !r.rom_done;

	generate
		for (genvar i = 0; i < 2; i++) begin : g_link
			assign link_init_start_o[i] = r.init_busy[i];
			assign link_tx_enable_o[i] = r.init_complete[i] &
				~(r.chain_end[i] & r.tx_disable[i]);
			assign chain_end_handle_o[i] = r.chain_end[i] | ~r.init_complete[i];
		end
	endgenerate

	// Configuration claim by unit identifier
	assign claim_hit = claim_match(r.base_uid, cfg_device_i);
	assign cfg_claim_o = cfg_req_i && claim_hit;
	assign cfg_forward_o = cfg_req_i && !claim_hit;
	assign unit_id_o = r.base_uid;

	// Secondary bus
	assign secondary_bus_reset_n_o = !(in_reset || !r.rst_s || r.sbr);
	assign buffer_flush_o = r.flush;
	assign inbound_write_drop_o = r.sbr && inbound_write_i && !inbound_write_committed_i;
	assign read_data_discard_o = r.rd_discard;
	assign outbound_master_abort_o = r.ob_abort;

	// Single-port power saving from straps
	assign port1_clk_enable_o = !single_port(r);
	assign port1_pad_power_down_o = narrow_pads(r);

endmodule

// ==== tb/brli_asserts.sv ====
// Port checker for the reset sequencer, bound to the top module
`timescale 1ns/100ps
module brli_asserts (
	input logic sys_clk_i,
	input logic rst_b_i,
	input logic power_good_i,
	input logic sys_reset_n_i,
	input logic sys_reset_n_oe_o,
	input logic pll_lock_i,
	input logic rom_load_req_o,
	input logic secondary_bus_reset_n_o,
	input logic cfg_req_i,
	input logic [4:0] cfg_device_i,
	input logic cfg_claim_o,
	input logic cfg_forward_o,
	input logic [4:0] unit_id_o,
	input logic inbound_write_i,
	input logic inbound_write_committed_i,
	input logic inbound_write_drop_o,
	input logic inbound_read_resp_i,
	input logic read_data_discard_o,
	input logic outbound_op_i,
	input logic outbound_master_abort_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence pg_lost;
		!power_good_i [*4];
	endsequence
	sequence pin_low;
		!sys_reset_n_i [*3];
	endsequence
	cold_entry_a: assert property (pg_lost |=> sys_reset_n_oe_o)
		else $error("Reset pin not driven after power loss");
	bus_held_a: assert property (pin_low |=> !secondary_bus_reset_n_o)
		else $error("Secondary bus left reset while pin low");
	stretch_lock_a: assert property ($fell(sys_reset_n_oe_o) |-> pll_lock_i && !rom_load_req_o)
		else $error("Reset pin released before lock");
	claim_zero_a: assert property (cfg_req_i && unit_id_o == 5'h00
		|-> cfg_claim_o == (cfg_device_i == 5'h00))
		else $error("Wrong claim with base zero");
	forward_zero_a: assert property (cfg_req_i && unit_id_o != 5'h00 && cfg_device_i == 5'h00
		|-> cfg_forward_o && !cfg_claim_o)
		else $error("Device zero not forwarded");
	write_drop_a: assert property (inbound_write_drop_o
		|-> inbound_write_i && !inbound_write_committed_i)
		else $error("Committed write dropped");
	read_retire_a: assert property (read_data_discard_o |-> $past(inbound_read_resp_i))
		else $error("Discard without response");
	abort_cause_a: assert property (outbound_master_abort_o |-> $past(outbound_op_i))
		else $error("Abort without operation");
endmodule
bind brli_sequencer brli_asserts brli_asserts_i (.*);

// ==== tb/brli_partner.sv ====
// Board supervisor, clock and ROM source, and the two link peers
`timescale 1ns/100ps
module brli_partner #(
	parameter int HOLD = 20,
	parameter logic [31:0] ROM_WORD = 32'h3c5a_0f01
) (
	input logic sys_clk_i,
	input logic cold_i,
	input logic warm_i,
	input logic [1:0] fail_i,
	input logic rom_load_req_i,
	input logic [1:0] link_init_start_i,
	output logic power_good_o = 1'b0,
	output logic reset_pull_o = 1'b1,
	output logic pll_lock_o = 1'b0,
	output logic rom_load_valid_o = 1'b0,
	output logic [31:0] rom_load_data_o = 32'h0,
	output logic [1:0] link_init_ok_o = 2'h0,
	output logic [1:0] link_init_fail_o = 2'h0
);
	int cnt = 0;
	logic give;
	assign give = rom_load_req_i & ~rom_load_valid_o & cnt[0];
	always @(posedge sys_clk_i) begin
		cnt <= cold_i ? 0 : cnt + int'(cnt <= 3 * HOLD);
		power_good_o <= !cold_i && cnt >= HOLD;
		reset_pull_o <= cnt < 2 * HOLD || warm_i;
		pll_lock_o <= cnt >= HOLD + 4;
		rom_load_valid_o <= give;
		rom_load_data_o <= give ? ROM_WORD : ~rom_load_data_o;
		link_init_ok_o <= link_init_start_i & ~link_init_ok_o & ~fail_i;
		link_init_fail_o <= link_init_start_i & ~link_init_fail_o & fail_i;
	end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
module tb;
	localparam int HOLD = 20;
	localparam logic [31:0] ROM = 32'h3c5a_0f01;
	logic sys_clk_i, rst_b_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o, cold, warm;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rom_load_data_i, first_port_addr_data_i, q;
	logic [1:0] htrans_i, link_init_start_o, link_init_ok_i, link_init_fail_i, sync_flood_i;
	logic [1:0] link_cmd_write_i, link_tx_enable_o, chain_end_handle_o, lfail;
	logic [2:0] hsize_i;
	logic [4:0] cfg_device_i, unit_id_o;
	logic power_good_i, sys_reset_n_i, sys_reset_n_o, sys_reset_n_oe_o, pll_lock_i, pull;
	logic rom_load_req_o, rom_load_valid_i, cfg_req_i, cfg_claim_o, cfg_forward_o;
	logic secondary_bus_reset_n_o, buffer_flush_o, inbound_write_i, inbound_write_committed_i;
	logic inbound_write_drop_o, inbound_read_resp_i, read_data_discard_o, outbound_op_i;
	logic outbound_master_abort_o, port1_clk_enable_o, port1_pad_power_down_o;
	int num_errors = 0;
	int checked = 0;
	assign hready_i = hreadyout_o;
	assign sys_reset_n_i = (sys_reset_n_oe_o ? sys_reset_n_o : 1'b1) && !pull;
	brli_sequencer #(.RESET_HOLD_CYCLES(HOLD)) brli_sequencer_i (.*);
	brli_partner #(.HOLD(HOLD), .ROM_WORD(ROM)) brli_partner_i (.sys_clk_i, .cold_i(cold),
		.warm_i(warm), .fail_i(lfail), .rom_load_req_i(rom_load_req_o),
		.link_init_start_i(link_init_start_o), .power_good_o(power_good_i),
		.reset_pull_o(pull), .pll_lock_o(pll_lock_i), .rom_load_valid_o(rom_load_valid_i),
		.rom_load_data_o(rom_load_data_i), .link_init_ok_o(link_init_ok_i),
		.link_init_fail_o(link_init_fail_i));
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		hsel_i <= 1'b1;
		htrans_i <= brli_pkg::HTRANS_NONSEQ;
		hwrite_i <= w;
		haddr_i <= {24'h0, a};
		do @(posedge sys_clk_i); while (hready_i !== 1'b1);
		htrans_i <= 2'h0;
		hsel_i <= 1'b0;
		hwdata_i <= d;
		do @(posedge sys_clk_i); while (hready_i !== 1'b1);
		q = hrdata_o;
	endtask
	task automatic settle(input logic [5:0] e);
		q = '0;
		for (int i = 0; i < 200 && q[1:0] !== 2'h2; i++) bus(1'b0, brli_pkg::REG_STATUS, 0);
		chk(q[7:0], {e, 2'h2});
	endtask
	task automatic t_boot;
		settle(6'b000011);
		first_port_addr_data_i <= 32'h1;
		bus(1'b0, brli_pkg::REG_STRAP, 0);
		chk(q, 32'h3);
		bus(1'b0, brli_pkg::REG_ROM_CFG, 0);
		chk(q, ROM);
		chk({port1_clk_enable_o, port1_pad_power_down_o, unit_id_o}, 7'h20);
		$display("boot test done");
	endtask
	task automatic t_enum;
		link_cmd_write_i <= 2'b10;
		bus(1'b0, brli_pkg::REG_STATUS, 0);
		link_cmd_write_i <= 2'b00;
		bus(1'b0, brli_pkg::REG_STATUS, 0);
		chk(q[7:6], 2'b10);
		bus(1'b1, brli_pkg::REG_BASE_UID, 32'h3);
		cfg_req_i <= 1'b1;
		@(negedge sys_clk_i);
		chk({unit_id_o, cfg_claim_o, cfg_forward_o}, {5'h3, 2'b01});
		@(posedge sys_clk_i);
		cfg_device_i <= 5'h3;
		@(negedge sys_clk_i);
		chk({cfg_claim_o, cfg_forward_o}, 2'b10);
		bus(1'b1, brli_pkg::REG_LINK_CTRL, 32'ha);
		@(negedge sys_clk_i);
		chk({link_tx_enable_o, chain_end_handle_o}, 4'b0110);
		$display("enumeration test done");
	endtask
	task automatic t_sbr;
		int n;
		n = 0;
		bus(1'b1, brli_pkg::REG_BUS_CTRL, 32'h1);
		repeat (4) begin
			@(negedge sys_clk_i);
			n += int'(buffer_flush_o === 1'b1);
		end
		chk(n, 1);
		chk(secondary_bus_reset_n_o, 1'b0);
		@(posedge sys_clk_i);
		inbound_write_i <= 1'b1;
		inbound_read_resp_i <= 1'b1;
		outbound_op_i <= 1'b1;
		@(negedge sys_clk_i);
		chk(inbound_write_drop_o, 1'b1);
		@(posedge sys_clk_i);
		inbound_write_committed_i <= 1'b1;
		inbound_read_resp_i <= 1'b0;
		outbound_op_i <= 1'b0;
		@(negedge sys_clk_i);
		chk({inbound_write_drop_o, read_data_discard_o, outbound_master_abort_o}, 3'h3);
		bus(1'b1, brli_pkg::REG_BUS_CTRL, 32'h0);
		outbound_op_i <= 1'b1;
		@(posedge sys_clk_i);
		outbound_op_i <= 1'b0;
		@(negedge sys_clk_i);
		chk({secondary_bus_reset_n_o, outbound_master_abort_o}, 2'b10);
		bus(1'b0, brli_pkg::REG_STATUS, 0);
		chk(q[3:2], 2'b11);
		chk(q[9:4], 6'h38);
		$display("secondary reset test done");
	endtask
	task automatic t_warm;
		sync_flood_i <= 2'b01;
		lfail <= 2'b10;
		@(posedge sys_clk_i);
		sync_flood_i <= 2'b00;
		warm <= 1'b1;
		repeat (HOLD) @(negedge sys_clk_i);
		chk(secondary_bus_reset_n_o, 1'b0);
		@(posedge sys_clk_i);
		warm <= 1'b0;
		settle(6'b000100);
		lfail <= 2'b00;
		bus(1'b0, brli_pkg::REG_STRAP, 0);
		chk({q, unit_id_o, cfg_claim_o}, {32'h3, 6'h0});
		$display("warm reset test done");
	endtask
	task automatic t_cold;
		cold <= 1'b1;
		repeat (8) @(negedge sys_clk_i);
		chk(sys_reset_n_oe_o, 1'b1);
		@(posedge sys_clk_i);
		cold <= 1'b0;
		settle(6'b000011);
		bus(1'b0, brli_pkg::REG_STRAP, 0);
		chk(q, 32'h1);
		chk({port1_clk_enable_o, port1_pad_power_down_o}, 2'b00);
		$display("cold reset test done");
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		repeat (10000) @(posedge sys_clk_i);
		num_errors++;
		report_and_stop();
	end
	initial begin
		{rst_b_i, hsel_i, hwrite_i, cfg_req_i, cold, warm, inbound_write_i} = '0;
		{inbound_write_committed_i, inbound_read_resp_i, outbound_op_i, haddr_i, hwdata_i} = '0;
		{htrans_i, sync_flood_i, link_cmd_write_i, lfail, cfg_device_i} = '0;
		hsize_i = 3'h2;
		first_port_addr_data_i = 32'h3;
		repeat (12) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		t_boot();
		t_enum();
		t_sbr();
		t_warm();
		t_cold();
		report_and_stop();
	end
endmodule
